/* src/pts_pkg.sv */
package pts_pkg;

	// Status word layout.
	localparam int PSW_TRACE_BIT = 4;

	// Vector byte addresses in low memory; the status word sits one word above.
	localparam logic [15:0] VEC_BUS_ILLEGAL = 16'h0004;
	localparam logic [15:0] VEC_RESERVED = 16'h0008;
	localparam logic [15:0] VEC_TRACE = 16'h000C;
	localparam logic [15:0] VEC_IO_TRAP = 16'h0010;
	localparam logic [15:0] VEC_POWER_FAIL = 16'h0014;
	localparam logic [15:0] VEC_EMULATOR = 16'h0018;
	localparam logic [15:0] VEC_SOFT_TRAP = 16'h001C;
	localparam logic [15:0] VEC_PSW_OFFSET = 16'h0002;
	localparam logic [15:0] WORD_STEP = 16'h0002;

	// Opcodes decoded by the sequencer.
	localparam logic [15:0] OP_HALT = 16'h0000;
	localparam logic [15:0] OP_WAIT = 16'h0001;
	localparam logic [15:0] OP_RETURN_FROM_INTERRUPT = 16'h0002;
	localparam logic [15:0] OP_BREAKPOINT = 16'h0003;
	localparam logic [15:0] OP_IO_TRAP = 16'h0004;
	localparam logic [15:0] OP_RETURN_NO_TRACE = 16'h0006;
	localparam logic [6:0] OP_EMULATOR_TRAP_HI = 7'h44;
	localparam logic [9:0] OP_JUMP_HI = 10'h001;
	localparam logic [6:0] OP_CALL_HI = 7'h04;
	localparam logic [5:0] OP_RESERVED_LOW_MIN = 6'h07;
	localparam logic [6:0] OP_RESERVED_MID_HI = 7'h07;
	localparam logic [15:0] OP_RESERVED_HIGH_MIN = 16'h8D00;
	localparam logic [15:0] OP_RESERVED_HIGH_MAX = 16'h8FFF;

	// Timing at the 200 MHz processor clock.
	localparam int CLK_KHZ = 200000;
	localparam int BUS_TIMEOUT_US = 10;
	localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_US * CLK_KHZ / 1000;
	localparam int POWER_DOWN_MS = 2;
	localparam int POWER_DOWN_CYC = POWER_DOWN_MS * CLK_KHZ;
	localparam int TIMEOUT_CNT_W = 11;
	localparam int POWER_CNT_W = 19;

	// Sequencer states.
	typedef enum logic [3:0] {
		SEQ_IDLE,
		SEQ_PUSH_PSW,
		SEQ_PUSH_PC,
		SEQ_READ_PC,
		SEQ_READ_PSW,
		SEQ_POP_PC,
		SEQ_POP_PSW,
		SEQ_FINISH,
		SEQ_HALTED
	} pts_seq_t;

endpackage

/* src/pts_bus_watch.sv */
`timescale 1ns/10ps
// Watches one bus access at a time for odd word addresses and missing replies.
module pts_bus_watch (
	input wire logic clk,
	input wire logic rst,
	input wire logic active,
	input wire logic addr_lsb,
	input wire logic word_access,
	input wire logic reply,
	output logic odd_err,
	output logic timeout_err
);

	typedef struct packed {
		logic active_prev;
		logic odd;
		logic tout;
		logic fired;
		logic [pts_pkg::TIMEOUT_CNT_W-1:0] cnt;
	} pts_watch_t;

	pts_watch_t s_q;
	pts_watch_t s_d;

	// The count is cleared by every reply, so only an access left unanswered for BUS_TIMEOUT_CYC cycles trips it.
	always_comb begin
		s_d = s_q;
		s_d.active_prev = active;
		s_d.odd = active && !s_q.active_prev && word_access && addr_lsb;
		s_d.tout = 1'b0;
		if (!active || reply) begin
			s_d.cnt = '0;
			s_d.fired = 1'b0;
		end else if (!s_q.fired) begin
			if (s_q.cnt == pts_pkg::TIMEOUT_CNT_W'(pts_pkg::BUS_TIMEOUT_CYC - 1)) begin
				s_d.tout = 1'b1;
				s_d.fired = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign odd_err = s_q.odd;
	assign timeout_err = s_q.tout;

	AST_TIMEOUT_COUNT: assert property (@(posedge clk) disable iff (rst)
		$rose(s_q.tout) |-> $past(active) && !$past(reply) && $past(s_q.cnt) ==
		pts_pkg::TIMEOUT_CNT_W'(pts_pkg::BUS_TIMEOUT_CYC - 1))
		else $error("Bus timeout fired at the wrong count.");

endmodule

/* src/pts_trap_sequencer.sv */
`timescale 1ns/10ps
module pts_trap_sequencer #(
	parameter int POWER_DOWN_CYC = pts_pkg::POWER_DOWN_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic fetch_valid,
	input wire logic [15:0] fetch_word,
	input wire logic exec_done,
	input wire logic stack_overflow,
	input wire logic [15:0] psw_in,
	input wire logic [15:0] pc_in,
	input wire logic [15:0] sp_in,
	input wire logic bus_active,
	input wire logic [15:0] bus_addr,
	input wire logic bus_word,
	input wire logic bus_reply,
	input wire logic power_fail,
	input wire logic console_continue,
	output logic mem_req,
	output logic mem_write,
	output logic [15:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_reply,
	output logic busy,
	output logic load_state,
	output logic [15:0] new_pc,
	output logic [15:0] new_psw,
	output logic [15:0] new_sp,
	output logic halted,
	output logic power_down_done
);

	typedef struct packed {
		pts_pkg::pts_seq_t st;
		logic [15:0] sp;
		logic [15:0] pc;
		logic [15:0] sav_psw;
		logic [15:0] vec;
		logic [15:0] maddr;
		logic [15:0] mwdata;
		logic [15:0] npc;
		logic [15:0] npsw;
		logic mwe;
		logic load;
		logic trace_flag;
		logic ret_full;
		logic ovf_after;
		logic pf_prev;
		logic pf_pend;
		logic pf_timing;
		logic pf_done;
		logic [pts_pkg::POWER_CNT_W-1:0] pf_cnt;
	} pts_state_t;

	pts_state_t s_q;
	pts_state_t s_d;
	logic odd_err;
	logic timeout_err;
	logic bus_err;
	logic [15:0] fetch_vec;
	logic pf_take;

	////////////////////////////////////////////////////////////////////////////////

	// Returns the vector of an instruction that traps at fetch, or zero if none.
	function automatic logic [15:0] pts_trap_vector(input logic [15:0] w);
		logic [15:0] v;
		v = '0;
		if (w == pts_pkg::OP_IO_TRAP) begin
			v = pts_pkg::VEC_IO_TRAP;
		end else if (w == pts_pkg::OP_BREAKPOINT) begin
			v = pts_pkg::VEC_TRACE;
		end else if (w[15:9] == pts_pkg::OP_EMULATOR_TRAP_HI) begin
			v = w[8] ? pts_pkg::VEC_SOFT_TRAP : pts_pkg::VEC_EMULATOR;
		end else if ((w[15:6] == pts_pkg::OP_JUMP_HI || w[15:9] == pts_pkg::OP_CALL_HI)
				&& w[5:3] == 3'h0) begin
			v = pts_pkg::VEC_BUS_ILLEGAL;
		end else if ((w[15:6] == 10'h000 && w[5:0] >= pts_pkg::OP_RESERVED_LOW_MIN)
				|| w[15:9] == pts_pkg::OP_RESERVED_MID_HI
				|| (w >= pts_pkg::OP_RESERVED_HIGH_MIN && w <= pts_pkg::OP_RESERVED_HIGH_MAX))
				begin
			v = pts_pkg::VEC_RESERVED;
		end
		return v;
	endfunction

	// True in states that hold a stack or vector access open on the memory port.
	function automatic logic pts_mem_state(input pts_pkg::pts_seq_t st);
		return st == pts_pkg::SEQ_PUSH_PSW || st == pts_pkg::SEQ_PUSH_PC
			|| st == pts_pkg::SEQ_READ_PC || st == pts_pkg::SEQ_READ_PSW
			|| st == pts_pkg::SEQ_POP_PC || st == pts_pkg::SEQ_POP_PSW;
	endfunction

	// Opens a trap: first push is the status word one word below the stack top.
	function automatic pts_state_t pts_start_trap(input pts_state_t s, input logic [15:0] v,
			input logic [15:0] pc, input logic [15:0] psw, input logic [15:0] sp);
		pts_state_t r;
		r = s;
		r.st = pts_pkg::SEQ_PUSH_PSW;
		r.vec = v;
		r.pc = pc;
		r.sav_psw = psw;
		r.sp = sp - pts_pkg::WORD_STEP;
		r.maddr = sp - pts_pkg::WORD_STEP;
		r.mwdata = psw;
		r.mwe = 1'b1;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	// One watchdog serves both the core's accesses and the sequencer's own.
	pts_bus_watch u_watch (
		.clk(clk),
		.rst(rst),
		.active(pts_mem_state(s_q.st) ? 1'b1 : bus_active),
		.addr_lsb(pts_mem_state(s_q.st) ? s_q.maddr[0] : bus_addr[0]),
		.word_access(pts_mem_state(s_q.st) ? 1'b1 : bus_word),
		.reply(pts_mem_state(s_q.st) ? mem_reply : bus_reply),
		.odd_err(odd_err),
		.timeout_err(timeout_err)
	);

	assign bus_err = odd_err || timeout_err;
	assign fetch_vec = pts_trap_vector(fetch_word);
	assign pf_take = s_q.st == pts_pkg::SEQ_IDLE && !bus_err && !fetch_valid && exec_done
		&& !s_q.trace_flag && !stack_overflow && s_q.pf_pend;

	////////////////////////////////////////////////////////////////////////////////

	// Sequencer. In the idle state the if-chain order is the trap priority.
	always_comb begin
		s_d = s_q;
		s_d.load = 1'b0;
		s_d.pf_prev = power_fail;
		// A new power failure edge wins over the clear of its own take.
		s_d.pf_pend = (s_q.pf_pend && !pf_take) || (power_fail && !s_q.pf_prev);
		if (s_q.pf_timing && !s_q.pf_done) begin
			if (s_q.pf_cnt == pts_pkg::POWER_CNT_W'(POWER_DOWN_CYC - 1)) begin
				s_d.pf_done = 1'b1;
			end else begin
				s_d.pf_cnt = s_q.pf_cnt + 1'b1;
			end
		end
		case (s_q.st)
			pts_pkg::SEQ_IDLE: begin
				if (bus_err) begin
					// Odd address and timeout both take the bus-error vector; the watchdog ranks neither above the other.
					s_d = pts_start_trap(s_d, pts_pkg::VEC_BUS_ILLEGAL, pc_in, psw_in, sp_in);
					s_d.trace_flag = 1'b0;
					s_d.ovf_after = 1'b0;
				end else if (fetch_valid) begin
					// Trace is caught only here, so an earlier interrupt runs untraced.
					s_d.trace_flag = psw_in[pts_pkg::PSW_TRACE_BIT];
					s_d.ret_full = 1'b0;
					s_d.ovf_after = 1'b0;
					if (fetch_vec != 16'h0000) begin
						s_d = pts_start_trap(s_d, fetch_vec, pc_in, psw_in, sp_in);
						s_d.trace_flag = 1'b0;
					end else if (fetch_word == pts_pkg::OP_RETURN_FROM_INTERRUPT
							|| fetch_word == pts_pkg::OP_RETURN_NO_TRACE) begin
						s_d.st = pts_pkg::SEQ_POP_PC;
						s_d.sp = sp_in;
						s_d.maddr = sp_in;
						s_d.mwe = 1'b0;
						s_d.ret_full = fetch_word == pts_pkg::OP_RETURN_FROM_INTERRUPT;
						if (fetch_word == pts_pkg::OP_RETURN_NO_TRACE) begin
							s_d.trace_flag = 1'b0;
						end
					end else if (fetch_word == pts_pkg::OP_WAIT
							&& psw_in[pts_pkg::PSW_TRACE_BIT]) begin
						s_d = pts_start_trap(s_d, pts_pkg::VEC_TRACE, pc_in, psw_in, sp_in);
						s_d.trace_flag = 1'b0;
					end else if (fetch_word == pts_pkg::OP_HALT) begin
						s_d.st = pts_pkg::SEQ_HALTED;
						s_d.trace_flag = 1'b0;
					end
				end else if (exec_done) begin
					if (s_q.trace_flag) begin
						// The traced status word is the one left by the instruction.
						s_d = pts_start_trap(s_d, pts_pkg::VEC_TRACE, pc_in, psw_in, sp_in);
						s_d.ovf_after = stack_overflow;
						s_d.trace_flag = 1'b0;
					end else if (stack_overflow) begin
						s_d = pts_start_trap(s_d, pts_pkg::VEC_BUS_ILLEGAL, pc_in, psw_in, sp_in);
					end else if (s_q.pf_pend) begin
						s_d = pts_start_trap(s_d, pts_pkg::VEC_POWER_FAIL, pc_in, psw_in, sp_in);
					end
				end
			end
			pts_pkg::SEQ_PUSH_PSW: begin
				if (mem_reply) begin
					s_d.st = pts_pkg::SEQ_PUSH_PC;
					s_d.sp = s_q.sp - pts_pkg::WORD_STEP;
					s_d.maddr = s_q.sp - pts_pkg::WORD_STEP;
					s_d.mwdata = s_q.pc;
				end
			end
			pts_pkg::SEQ_PUSH_PC: begin
				if (mem_reply) begin
					s_d.st = pts_pkg::SEQ_READ_PC;
					s_d.maddr = s_q.vec;
					s_d.mwe = 1'b0;
				end
			end
			pts_pkg::SEQ_READ_PC: begin
				if (mem_reply) begin
					s_d.st = pts_pkg::SEQ_READ_PSW;
					s_d.npc = mem_rdata;
					s_d.maddr = s_q.vec + pts_pkg::VEC_PSW_OFFSET;
				end
			end
			pts_pkg::SEQ_POP_PC: begin
				if (mem_reply) begin
					s_d.st = pts_pkg::SEQ_POP_PSW;
					s_d.npc = mem_rdata;
					s_d.sp = s_q.sp + pts_pkg::WORD_STEP;
					s_d.maddr = s_q.sp + pts_pkg::WORD_STEP;
				end
			end
			pts_pkg::SEQ_READ_PSW, pts_pkg::SEQ_POP_PSW: begin
				if (mem_reply) begin
					s_d.st = pts_pkg::SEQ_FINISH;
					s_d.npsw = mem_rdata;
					s_d.load = 1'b1;
					if (s_q.st == pts_pkg::SEQ_POP_PSW) begin
						s_d.sp = s_q.sp + pts_pkg::WORD_STEP;
					end
				end
			end
			pts_pkg::SEQ_FINISH: begin
				// Interrupts are not held off here; the loaded priority must do that.
				s_d.st = pts_pkg::SEQ_IDLE;
				if (s_q.vec == pts_pkg::VEC_POWER_FAIL && !s_q.ret_full) begin
					s_d.pf_timing = 1'b1;
				end
				if (s_q.ovf_after) begin
					s_d = pts_start_trap(s_d, pts_pkg::VEC_BUS_ILLEGAL, s_q.npc, s_q.npsw, s_q.sp);
					s_d.ovf_after = 1'b0;
				end else if (s_q.ret_full
						&& (s_q.trace_flag || s_q.npsw[pts_pkg::PSW_TRACE_BIT])) begin
					s_d = pts_start_trap(s_d, pts_pkg::VEC_TRACE, s_q.npc, s_q.npsw, s_q.sp);
				end
				s_d.trace_flag = 1'b0;
				s_d.ret_full = 1'b0;
			end
			pts_pkg::SEQ_HALTED: begin
				if (console_continue) begin
					s_d.st = pts_pkg::SEQ_IDLE;
				end
			end
			default: begin
				s_d.st = pts_pkg::SEQ_IDLE;
			end
		endcase
		// A bus error inside any trap sequence is fatal.
		if (bus_err && pts_mem_state(s_q.st)) begin
			s_d.st = pts_pkg::SEQ_HALTED;
			s_d.ovf_after = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	// Outputs; the core stalls while busy and takes new state on the load pulse.
	assign mem_req = pts_mem_state(s_q.st);
	assign mem_write = s_q.mwe && mem_req;
	assign mem_addr = s_q.maddr;
	assign mem_wdata = s_q.mwdata;
	assign busy = s_q.st != pts_pkg::SEQ_IDLE;
	assign load_state = s_q.load;
	assign new_pc = s_q.npc;
	assign new_psw = s_q.npsw;
	assign new_sp = s_q.sp;
	assign halted = s_q.st == pts_pkg::SEQ_HALTED;
	assign power_down_done = s_q.pf_done;

	////////////////////////////////////////////////////////////////////////////////

	AST_PUSH_THEN_PC: assert property (@(posedge clk) disable iff (rst)
		s_q.st == pts_pkg::SEQ_PUSH_PSW && mem_reply && !bus_err |=> s_q.st ==
		pts_pkg::SEQ_PUSH_PC && mem_write && mem_wdata == s_q.pc && mem_addr == $past(mem_addr) - 16'h0002)
		else $error("Program counter push did not follow status push.");
	AST_VECTOR_PSW_ADDR: assert property (@(posedge clk) disable iff (rst)
		s_q.st == pts_pkg::SEQ_READ_PSW |-> mem_addr == s_q.vec + 16'h0002 && !mem_write)
		else $error("Vector status word read at wrong address.");
	AST_IO_TRAP_VEC: assert property (@(posedge clk) disable iff (rst)
		s_q.st == pts_pkg::SEQ_IDLE && !bus_err && fetch_valid && fetch_word == 16'h0004
		|=> s_q.st == pts_pkg::SEQ_PUSH_PSW && s_q.vec == 16'h0010)
		else $error("I/O trap did not use its vector.");
	AST_REG_JUMP_ILLEGAL: assert property (@(posedge clk) disable iff (rst)
		s_q.st == pts_pkg::SEQ_IDLE && !bus_err && fetch_valid && fetch_word[15:3] == 13'h0008
		|=> s_q.vec == 16'h0004)
		else $error("Register-mode jump was not trapped as illegal.");
	AST_BERR_HALTS: assert property (@(posedge clk) disable iff (rst)
		bus_err && mem_req |=> halted)
		else $error("Bus error inside a trap sequence did not halt.");
	AST_RET_TRACE: assert property (@(posedge clk) disable iff (rst)
		s_q.st == pts_pkg::SEQ_FINISH && s_q.ret_full && !s_q.ovf_after && new_psw[4]
		|=> s_q.st == pts_pkg::SEQ_PUSH_PSW && s_q.vec == 16'h000C && mem_wdata == $past(new_psw))
		else $error("Return restoring trace did not trace at once.");
	AST_RET_NO_TRACE: assert property (@(posedge clk) disable iff (rst)
		s_q.st == pts_pkg::SEQ_IDLE && !bus_err && fetch_valid && fetch_word == 16'h0006
		|=> !s_q.trace_flag && !s_q.ret_full)
		else $error("Return without trace left a trace pending.");
	AST_WAIT_TRACE: assert property (@(posedge clk) disable iff (rst)
		s_q.st == pts_pkg::SEQ_IDLE && !bus_err && fetch_valid && fetch_word == 16'h0001 && psw_in[4]
		|=> s_q.st == pts_pkg::SEQ_PUSH_PSW && s_q.vec == 16'h000C)
		else $error("Traced wait did not trap at once.");
	AST_TRACE_BEATS_OVF: assert property (@(posedge clk) disable iff (rst)
		s_q.st == pts_pkg::SEQ_IDLE && !bus_err && !fetch_valid && exec_done && s_q.trace_flag
		&& stack_overflow |=> s_q.vec == 16'h000C && s_q.ovf_after)
		else $error("Traced overflow did not defer behind the trace trap.");
	AST_BERR_FIRST: assert property (@(posedge clk) disable iff (rst)
		s_q.st == pts_pkg::SEQ_IDLE && bus_err |=> s_q.vec == 16'h0004 && !s_q.trace_flag)
		else $error("Bus error lost to a lower trap.");

	COV_TRACE_TRAP: cover property (@(posedge clk) disable iff (rst)
		s_q.st == pts_pkg::SEQ_FINISH && s_q.vec == 16'h000C);
	COV_RTI_POP: cover property (@(posedge clk) disable iff (rst)
		s_q.st == pts_pkg::SEQ_POP_PSW ##1 load_state);
	COV_POWER_TRAP: cover property (@(posedge clk) disable iff (rst)
		s_q.st == pts_pkg::SEQ_FINISH && s_q.vec == 16'h0014);

endmodule

/* tb/pts_mem_model.sv */
`timescale 1ns/10ps
// Memory seen by the sequencer: it answers each access after lat idle cycles.
module pts_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata,
	output logic mem_reply
);
	logic [15:0] mem [0:32767];
	logic [31:0] wlog [$];
	int lat;
	int cnt;

	initial begin
		lat = 0;
		cnt = 0;
		mem_reply = 1'b0;
		mem_rdata = 16'h0000;
	end

	////////////////////////////////////////////////////////////////
	// One reply pulse for each access, then one quiet cycle, so that the
	// next address is never answered early. Read data are valid only with
	// the reply; otherwise they flip every cycle so stale use shows up.
	always @(posedge clk) begin
		if (rst || mem_reply) begin
			mem_reply <= 1'b0;
			cnt <= 0;
			mem_rdata <= ~mem_rdata;
		end else if (mem_req && cnt >= lat) begin
			mem_reply <= 1'b1;
			if (mem_write) begin
				mem[mem_addr[15:1]] <= mem_wdata;
				wlog.push_back({mem_addr, mem_wdata});
				mem_rdata <= ~mem_rdata;
			end else begin
				mem_rdata <= mem[mem_addr[15:1]];
			end
		end else begin
			cnt <= mem_req ? cnt + 1 : cnt;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule

/* tb/processor_trap_sequencer_tb_top.sv */
`timescale 1ns/10ps
// Drives the core side of the sequencer and judges every trap it takes.
module processor_trap_sequencer_tb_top;
	logic clk, rst, fetch_valid, exec_done, stack_overflow, bus_active, bus_word, bus_reply;
	logic power_fail, console_continue, mem_req, mem_write, mem_reply, busy, load_state;
	logic halted, power_down_done;
	logic [15:0] fetch_word, psw_in, pc_in, sp_in, bus_addr, mem_addr, mem_wdata, mem_rdata;
	logic [15:0] new_pc, new_psw, new_sp;
	int num_errors, check_count, loads;

	// A short power-down count keeps the run brief.
	pts_trap_sequencer #(.POWER_DOWN_CYC(20)) u_dut (.clk, .rst, .fetch_valid, .fetch_word,
		.exec_done, .stack_overflow, .psw_in, .pc_in, .sp_in, .bus_active, .bus_addr,
		.bus_word, .bus_reply, .power_fail, .console_continue, .mem_req, .mem_write,
		.mem_addr, .mem_wdata, .mem_rdata, .mem_reply, .busy, .load_state, .new_pc,
		.new_psw, .new_sp, .halted, .power_down_done);
	pts_mem_model u_mem (.clk, .rst, .mem_req, .mem_write, .mem_addr, .mem_wdata,
		.mem_rdata, .mem_reply);

	// Clock at 200 MHz.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Counts load pulses so that a missing or an extra trap shows up.
	initial loads = 0;
	always @(posedge clk) begin
		if (load_state === 1'b1) begin
			loads <= loads + 1;
		end
	end

	////////////////////////////////////////////////////////////////
	// Common helpers.
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Core state as the core would show it; also clears the write log.
	task automatic set_core(input logic [15:0] psw, input logic [15:0] pc, input logic [15:0] sp);
		@(posedge clk);
		psw_in <= psw;
		pc_in <= pc;
		sp_in <= sp;
		u_mem.wlog.delete();
	endtask

	task automatic fetch(input logic [15:0] w);
		@(posedge clk);
		fetch_valid <= 1'b1;
		fetch_word <= w;
		@(posedge clk);
		fetch_valid <= 1'b0;
	endtask

	task automatic finish_instr();
		@(posedge clk);
		exec_done <= 1'b1;
		@(posedge clk);
		exec_done <= 1'b0;
	endtask

	task automatic pulse_continue();
		@(posedge clk);
		console_continue <= 1'b1;
		@(posedge clk);
		console_continue <= 1'b0;
	endtask

	// Runs one instruction; completion is only signalled if no trap opened at fetch.
	task automatic run_instr(input logic [15:0] w);
		fetch(w);
		@(negedge clk);
		if (busy !== 1'b1) begin
			finish_instr();
		end
	endtask

	task automatic wait_load(input int max, output int n);
		n = 0;
		while (load_state !== 1'b1 && n < max) begin
			@(negedge clk);
			n++;
		end
		check("load_state", {15'h0, load_state}, 16'h0001);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		check("busy", {15'h0, busy}, 16'h0000);
	endtask

	// Waits for the vector load, then checks both pushes and the loaded state.
	task automatic expect_trap(input logic [15:0] vec, input logic [15:0] sp,
		input logic [15:0] psw, input logic [15:0] pc, input int max);
		int n;
		wait_load(max, n);
		check("new_pc", new_pc, 16'h1000 + vec);
		check("new_psw", new_psw, 16'h00EF);
		check("new_sp", new_sp, sp - 16'h0004);
		check("psw_push_adr", u_mem.wlog[0][31:16], sp - 16'h0002);
		check("psw_push", u_mem.wlog[0][15:0], psw);
		check("pc_push_adr", u_mem.wlog[1][31:16], sp - 16'h0004);
		check("pc_push", u_mem.wlog[1][15:0], pc);
		wait_idle();
	endtask

	task automatic bus_fault(input logic [15:0] addr, input int max, output int n);
		@(posedge clk);
		bus_active <= 1'b1;
		bus_addr <= addr;
		bus_word <= 1'b1;
		n = 0;
		while (busy !== 1'b1 && n < max) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		bus_active <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic t_io_trap();
		int l0;
		u_mem.lat = 2;
		set_core(16'h001F, 16'h0400, 16'h0800);
		l0 = loads;
		fetch(pts_pkg::OP_IO_TRAP);
		expect_trap(pts_pkg::VEC_IO_TRAP, 16'h0800, 16'h001F, 16'h0400, 100);
		repeat (8) @(negedge clk);
		check("io_loads", 16'(loads - l0), 16'h0001);
		u_mem.lat = 0;
		$display("done io_trap");
	endtask

	task automatic t_illegal();
		logic [15:0] ops [5] = '{16'h0007, 16'h0E00, 16'h8D00, 16'h0040, 16'h0800};
		logic [15:0] vecs [5] = '{16'h0008, 16'h0008, 16'h0008, 16'h0004, 16'h0004};
		for (int i = 0; i < 5; i++) begin
			set_core(16'h0000, 16'h0500, 16'h0900);
			run_instr(ops[i]);
			expect_trap(vecs[i], 16'h0900, 16'h0000, 16'h0500, 60);
		end
		$display("done illegal");
	endtask

	task automatic t_return();
		int n;
		int l0;
		u_mem.mem[16'h0500] = 16'h3330;
		u_mem.mem[16'h0501] = 16'h0013;
		set_core(16'h0000, 16'h0600, 16'h0A00);
		fetch(pts_pkg::OP_RETURN_FROM_INTERRUPT);
		wait_load(60, n);
		check("ret_pc", new_pc, 16'h3330);
		check("ret_psw", new_psw, 16'h0013);
		check("ret_sp", new_sp, 16'h0A04);
		@(negedge clk);
		wait_load(20, n);
		check("ret_trace_pc", new_pc, 16'h100C);
		wait_idle();
		set_core(16'h0010, 16'h0600, 16'h0A00);
		l0 = loads;
		fetch(pts_pkg::OP_RETURN_NO_TRACE);
		wait_load(60, n);
		check("notrace_psw", new_psw, 16'h0013);
		wait_idle();
		repeat (6) @(negedge clk);
		check("notrace_loads", 16'(loads - l0), 16'h0001);
		set_core(16'h0013, 16'h3330, 16'h0A04);
		run_instr(16'h00A0);
		expect_trap(pts_pkg::VEC_TRACE, 16'h0A04, 16'h0013, 16'h3330, 60);
		$display("done return");
	endtask

	task automatic t_trace();
		int l0;
		set_core(16'h0010, 16'h0700, 16'h0B00);
		fetch(16'h00A0);
		set_core(16'h0000, 16'h0702, 16'h0B00);
		finish_instr();
		expect_trap(pts_pkg::VEC_TRACE, 16'h0B00, 16'h0000, 16'h0702, 60);
		set_core(16'h0010, 16'h0704, 16'h0B00);
		run_instr(16'h00A0);
		expect_trap(pts_pkg::VEC_TRACE, 16'h0B00, 16'h0010, 16'h0704, 60);
		set_core(16'h0010, 16'h0706, 16'h0B00);
		fetch(pts_pkg::OP_WAIT);
		expect_trap(pts_pkg::VEC_TRACE, 16'h0B00, 16'h0010, 16'h0706, 60);
		set_core(16'h0000, 16'h0708, 16'h0B00);
		l0 = loads;
		run_instr(16'h00A0);
		repeat (8) @(negedge clk);
		check("untraced_loads", 16'(loads - l0), 16'h0000);
		// Traced overflow: trace trap first, then the overflow trap on the handler state.
		set_core(16'h0010, 16'h070A, 16'h0B00);
		fetch(16'h00A0);
		@(posedge clk);
		exec_done <= 1'b1;
		stack_overflow <= 1'b1;
		@(posedge clk);
		exec_done <= 1'b0;
		stack_overflow <= 1'b0;
		expect_trap(pts_pkg::VEC_TRACE, 16'h0B00, 16'h0010, 16'h070A, 60);
		check("ovf_pc", new_pc, 16'h1004);
		check("ovf_sp", new_sp, 16'h0AF8);
		check("ovf_psw_push", u_mem.wlog[2][15:0], 16'h00EF);
		check("ovf_pc_push", u_mem.wlog[3][15:0], 16'h100C);
		$display("done trace");
	endtask

	task automatic t_bus_errors();
		int n;
		set_core(16'h0000, 16'h0800, 16'h0C00);
		bus_active <= 1'b1;
		bus_addr <= 16'h1235;
		repeat (2) @(posedge clk);
		bus_reply <= 1'b1;
		@(posedge clk);
		bus_active <= 1'b0;
		bus_reply <= 1'b0;
		repeat (4) @(negedge clk);
		check("byte_odd_busy", {15'h0, busy}, 16'h0000);
		bus_fault(16'h1235, 10, n);
		expect_trap(pts_pkg::VEC_BUS_ILLEGAL, 16'h0C00, 16'h0000, 16'h0800, 60);
		u_mem.wlog.delete();
		bus_fault(16'h2000, 2100, n);
		check("timeout_span", {15'h0, n >= 1990 && n <= 2010}, 16'h0001);
		expect_trap(pts_pkg::VEC_BUS_ILLEGAL, 16'h0C00, 16'h0000, 16'h0800, 60);
		$display("done bus_errors");
	endtask

	task automatic t_power();
		int n;
		set_core(16'h0010, 16'h0900, 16'h0D00);
		power_fail <= 1'b1;
		run_instr(16'h00A0);
		expect_trap(pts_pkg::VEC_TRACE, 16'h0D00, 16'h0010, 16'h0900, 60);
		set_core(16'h0000, 16'h0902, 16'h0D00);
		run_instr(16'h00A0);
		expect_trap(pts_pkg::VEC_POWER_FAIL, 16'h0D00, 16'h0000, 16'h0902, 60);
		n = 0;
		while (power_down_done !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		check("power_down_span", {15'h0, n >= 16 && n <= 22}, 16'h0001);
		@(posedge clk);
		power_fail <= 1'b0;
		$display("done power");
	endtask

	task automatic t_halt();
		int n;
		set_core(16'h0010, 16'h0A00, 16'h0E00);
		fetch(pts_pkg::OP_HALT);
		repeat (3) @(negedge clk);
		check("halted", {15'h0, halted}, 16'h0001);
		pulse_continue();
		@(negedge clk);
		check("resumed", {15'h0, halted}, 16'h0000);
		run_instr(16'h00A0);
		expect_trap(pts_pkg::VEC_TRACE, 16'h0E00, 16'h0010, 16'h0A00, 60);
		// A stack push that is never answered must stop the processor.
		u_mem.lat = 5000;
		set_core(16'h0000, 16'h0A02, 16'h0E00);
		fetch(pts_pkg::OP_IO_TRAP);
		n = 0;
		while (halted !== 1'b1 && n < 2100) begin
			@(negedge clk);
			n++;
		end
		check("fatal_halt", {15'h0, halted}, 16'h0001);
		u_mem.lat = 0;
		pulse_continue();
		$display("done halt");
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence: vectors carry priority 7 so no interrupt slips in.
	initial begin
		num_errors = 0;
		check_count = 0;
		rst = 1'b1;
		{fetch_valid, exec_done, stack_overflow, bus_active, bus_word, bus_reply} = 6'h00;
		{power_fail, console_continue} = 2'h0;
		{fetch_word, psw_in, pc_in, sp_in, bus_addr} = 80'h0;
		for (int v = 4; v <= 20; v += 4) begin
			u_mem.mem[v / 2] = 16'h1000 + 16'(v);
			u_mem.mem[v / 2 + 1] = 16'h00EF;
		end
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_io_trap();
		t_illegal();
		t_return();
		t_trace();
		t_bus_errors();
		t_power();
		t_halt();
		report_and_stop();
	end

	// Whole run needs some 4500 cycles; a hang is cut off well past that.
	initial begin
		#100000;
		num_errors++;
		report_and_stop();
	end
endmodule
